// >>> ccdrt_defs.svh
`ifndef CCDRT_DEFS_SVH
`define CCDRT_DEFS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define CCDRT_CHARGE_W    14
`define CCDRT_COUNT_W     12
`define CCDRT_PTR_W       12

// ****************************************************************
// horizontal cycle figures, counted from line start
// ****************************************************************
`define CCDRT_COUNT_IDLE  12'hFFF
`define CCDRT_SRC_LAST    12'h3C8
`define CCDRT_FG_FIRST    12'h022
`define CCDRT_FG_LAST     12'h3EA
`define CCDRT_SW_FIRST    12'h03E
`define CCDRT_SW_LAST     12'h406
`define CCDRT_OUT_FIRST   12'h044
`define CCDRT_OUT_LAST    12'h40C
`define CCDRT_FG_STAGES   34
`define CCDRT_SW_STAGES   28
`define CCDRT_TAIL_STAGES 5
`define CCDRT_MULT_TAIL   4
`define CCDRT_ROW_DELAY   2072
`define CCDRT_PTR_LAST    12'h817

`endif

// >>> ccdrt_pkg.sv
package ccdrt_pkg;
`include "ccdrt_defs.svh"

    typedef struct packed
    {
        logic                         valid;
        logic [`CCDRT_CHARGE_W-1:0]   charge;
    } ccdrt_pix_t;

    typedef struct packed
    {
        logic low_gain_route_gate;
        logic multiplier_route_gate;
    } ccdrt_route_t;

endpackage

// >>> ccdrt_readout.sv
// Function
// - first pixel on sense output at cycle 34
// - first pixel on gain outputs at cycle 68
// - dual mode multiplied output lags two rows
// - single mode multiplied output lags one row
// - last pixel on gain outputs at 1036
// - sense output leads gain outputs by 34
`timescale 1ns/1ps
`include "ccdrt_defs.svh"

module ccdrt_readout
    import ccdrt_pkg::*;
(
    // clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_arst_n,
    // pins from the timing generator
    input  wire logic          i_horizontal_storage_clock,
    input  wire logic          i_line_start,
    input  wire ccdrt_route_t  i_route,
    // charge entering the horizontal shift register
    input  wire logic [`CCDRT_CHARGE_W-1:0] i_charge,
    // video outputs
    output ccdrt_pix_t         o_floating_gate_sense_out,
    output ccdrt_pix_t         o_low_gain_out,
    output ccdrt_pix_t         o_multiplied_out
);

    // ****************************************************************
    // pin synchronisers and edge detection
    // ****************************************************************
    logic          hclk_meta;
    logic          hclk_sync;
    logic          hclk_last;
    logic          line_meta;
    logic          line_sync;
    logic          line_last;
    ccdrt_route_t  route_meta;
    ccdrt_route_t  route_sync;

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            hclk_meta  <= 1'b0;
            hclk_sync  <= 1'b0;
            hclk_last  <= 1'b0;
            line_meta  <= 1'b0;
            line_sync  <= 1'b0;
            line_last  <= 1'b0;
            route_meta <= '0;
            route_sync <= '0;
        end
        else
        begin
            hclk_meta  <= i_horizontal_storage_clock;
            hclk_sync  <= hclk_meta;
            hclk_last  <= hclk_sync;
            line_meta  <= i_line_start;
            line_sync  <= line_meta;
            line_last  <= line_sync;
            route_meta <= i_route;
            route_sync <= route_meta;
        end
    end

    wire tick       = hclk_sync & ~hclk_last;
    wire line_pulse = line_sync & ~line_last;

    // ****************************************************************
    // horizontal cycle counter, idle until the first line start
    // ****************************************************************
    logic [`CCDRT_COUNT_W-1:0] hcount;
    logic [`CCDRT_COUNT_W-1:0] next_hcount;
    wire                       saturated = (hcount == `CCDRT_COUNT_IDLE);

    assign next_hcount = line_pulse ? '0 :
                         (tick && !saturated) ? hcount + 12'h001 : hcount;

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            hcount <= `CCDRT_COUNT_IDLE;
        end
        else
        begin
            hcount <= next_hcount;
        end
    end

    // ****************************************************************
    // shift chain to the sense node
    // ****************************************************************
    ccdrt_pix_t src;
    ccdrt_pix_t fg_chain [0:`CCDRT_FG_STAGES-2];
    ccdrt_pix_t sw_chain [0:`CCDRT_SW_STAGES-1];

    assign src.valid  = (hcount <= `CCDRT_SRC_LAST);
    assign src.charge = i_charge;

    genvar g;
    generate
        for (g = 0; g < `CCDRT_FG_STAGES - 1; g++)
        begin : g_fg
            always_ff @(posedge i_clock or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    fg_chain[g] <= '0;
                else if (tick)
                    fg_chain[g] <= (g == 0) ? src
                                            : fg_chain[(g == 0) ? 0 : g-1];
            end
        end
    endgenerate

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_floating_gate_sense_out <= '0;
        else if (tick)
            o_floating_gate_sense_out <= fg_chain[`CCDRT_FG_STAGES-2];
    end

    // ****************************************************************
    // hold between sensing and the charge switch
    // ****************************************************************
    generate
        for (g = 0; g < `CCDRT_SW_STAGES; g++)
        begin : g_sw
            always_ff @(posedge i_clock or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    sw_chain[g] <= '0;
                else if (tick)
                    sw_chain[g] <= (g == 0) ? o_floating_gate_sense_out
                                            : sw_chain[(g == 0) ? 0 : g-1];
            end
        end
    endgenerate

    // ****************************************************************
    // charge switch: exactly one gate pulsed picks the path
    // ****************************************************************
    ccdrt_pix_t sw_pix;
    ccdrt_pix_t lg_in;
    ccdrt_pix_t mult_in;
    ccdrt_pix_t mult_row;
    wire        to_lg   = route_sync.low_gain_route_gate &
                          ~route_sync.multiplier_route_gate;
    wire        to_mult = route_sync.multiplier_route_gate &
                          ~route_sync.low_gain_route_gate;

    assign sw_pix  = sw_chain[`CCDRT_SW_STAGES-1];
    assign lg_in   = to_lg   ? sw_pix : '0;
    assign mult_in = to_mult ? sw_pix : '0;

    ccdrt_pix_t lg_tail   [0:`CCDRT_TAIL_STAGES-1];
    ccdrt_pix_t mult_tail [0:`CCDRT_MULT_TAIL-1];

    generate
        for (g = 0; g < `CCDRT_TAIL_STAGES; g++)
        begin : g_lg
            always_ff @(posedge i_clock or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    lg_tail[g] <= '0;
                else if (tick)
                    lg_tail[g] <= (g == 0) ? lg_in
                                           : lg_tail[(g == 0) ? 0 : g-1];
            end
        end
        for (g = 0; g < `CCDRT_MULT_TAIL; g++)
        begin : g_mult
            always_ff @(posedge i_clock or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    mult_tail[g] <= '0;
                else if (tick)
                    mult_tail[g] <= (g == 0) ? mult_row
                                             : mult_tail[(g == 0) ? 0 : g-1];
            end
        end
    endgenerate

    // same delay serves both modes: two short rows equal one long row
    ccdrt_row_delay u_row_delay
    (
        .i_clock  (i_clock),
        .i_arst_n (i_arst_n),
        .i_shift  (tick),
        .i_pix    (mult_in),
        .o_pix    (mult_row)
    );

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_low_gain_out   <= '0;
            o_multiplied_out <= '0;
        end
        else if (tick)
        begin
            o_low_gain_out   <= lg_tail[`CCDRT_TAIL_STAGES-1];
            o_multiplied_out <= mult_tail[`CCDRT_MULT_TAIL-1];
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_route_lg;
        tick && to_lg && sw_pix.valid;
    endsequence

    sequence s_line;
        line_pulse;
    endsequence

    a_count_restart: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        s_line |=> (hcount == '0))
        else $error("cycle counter not cleared by line start");

    a_fg_window: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        o_floating_gate_sense_out.valid |->
            (hcount >= `CCDRT_FG_FIRST && hcount <= `CCDRT_FG_LAST))
        else $error("sense pixel outside its cycle window");

    a_sw_window: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        sw_pix.valid |->
            (hcount >= `CCDRT_SW_FIRST && hcount <= `CCDRT_SW_LAST))
        else $error("switch stage off its fixed lag");

    a_route_lg: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        s_route_lg |=> (lg_tail[0].valid && lg_tail[0] == $past(sw_pix)))
        else $error("low gain route lost the pixel");

    // judged only on the edge after an update: a line start may clear
    // the counter while the last pixel of the row still stands
    a_lg_window: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        ($past(tick) && o_low_gain_out.valid) |->
            (hcount >= `CCDRT_OUT_FIRST && hcount <= `CCDRT_OUT_LAST))
        else $error("low gain pixel outside its cycle window");

    a_mult_window: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        ($past(tick) && o_multiplied_out.valid) |->
            (hcount >= `CCDRT_OUT_FIRST && hcount <= `CCDRT_OUT_LAST))
        else $error("multiplied pixel not on its row cycle");

endmodule // ccdrt_readout

// >>> ccdrt_row_delay.sv
`timescale 1ns/1ps
`include "ccdrt_defs.svh"

module ccdrt_row_delay
    import ccdrt_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    // shift step and data
    input  wire logic        i_shift,
    input  wire ccdrt_pix_t  i_pix,
    output ccdrt_pix_t       o_pix
);

    // ****************************************************************
    // ring buffer, one entry per horizontal cycle
    // ****************************************************************
    ccdrt_pix_t                 mem [0:`CCDRT_ROW_DELAY-1];
    logic [`CCDRT_PTR_W-1:0]    ptr;
    logic [`CCDRT_PTR_W-1:0]    next_ptr;
    logic [`CCDRT_ROW_DELAY-1:0] filled;
    wire                        wrap = (ptr == `CCDRT_PTR_LAST);

    assign next_ptr = wrap ? '0 : ptr + 12'h001;

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ptr    <= '0;
            o_pix  <= '0;
            filled <= '0;
        end
        else if (i_shift)
        begin
            ptr         <= next_ptr;
            filled[ptr] <= 1'b1;
            // unwritten entries read as empty after reset
            o_pix       <= filled[ptr] ? mem[ptr] : '0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_shift)
        begin
            mem[ptr] <= i_pix;
        end
    end

endmodule // ccdrt_row_delay

// >>> ccdrt_timing_gen.sv
`timescale 1ns/1ps

module ccdrt_timing_gen
    import ccdrt_pkg::*;
(
    // clock and sensed video
    input  wire logic        i_clock,
    input  wire ccdrt_pix_t  i_sense,
    // pins to the sensor
    output logic             o_hclk,
    output logic             o_line_start,
    output ccdrt_route_t     o_route,
    output logic [13:0]      o_charge,
    output logic             o_clamp
);
    localparam logic [13:0] THRESH = 14'h0B4;
    // vertical intervals in system clocks of 8 ns: 0.48, 1.304, 1.504 us
    localparam int VT_A    = 60;
    localparam int VT_B    = 163;
    localparam int PD_XFER = 188;

    logic [1:0]  hist [0:28];
    logic [11:0] hcount;

    assign o_clamp = (hcount >= 12'h003) && (hcount < 12'h01F);

    initial
    begin
        o_hclk       = 1'b0;
        o_line_start = 1'b0;
        o_route      = '0;
        o_charge     = '0;
        hcount       = '0;
        foreach (hist[i])
            hist[i] = 2'b10;
    end

    // one row down the vertical register, shift clock held low
    task automatic row_transfer();
        repeat (VT_A) @(negedge i_clock);
        repeat (VT_B) @(negedge i_clock);
    endtask

    // photodiodes into the vertical register before the first row
    task automatic frame_transfer();
        repeat (PD_XFER) @(negedge i_clock);
    endtask

    task automatic start_line();
        row_transfer();
        @(negedge i_clock);
        o_line_start = 1'b1;
        hcount       = '0;
        repeat (4) @(negedge i_clock);
        o_line_start = 1'b0;
        repeat (4) @(negedge i_clock);
    endtask

    // eight clocks a pixel, so no period under 50 ns
    task automatic pixel(input logic [13:0] charge, input logic bad);
        for (int i = 28; i > 0; i--)
            hist[i] = hist[i - 1];
        hist[0] = (i_sense.valid && i_sense.charge < THRESH) ? 2'b01
                                                             : 2'b10;
        o_charge = charge;
        // decision used 28 pixels after it was sensed
        o_route  = bad ? 2'b11 : hist[28];
        o_hclk   = 1'b1;
        hcount   = hcount + 12'h001;
        repeat (4) @(negedge i_clock);
        o_hclk   = 1'b0;
        o_route  = 2'b00;
        repeat (4) @(negedge i_clock);
    endtask
endmodule // ccdrt_timing_gen

// >>> tb_top.sv
`timescale 1ns/1ps

module tb_top
    import ccdrt_pkg::*;
    ;
    logic         i_clock  = 1'b0;
    logic         i_arst_n = 1'b0;
    logic         hclk;
    logic         lstart;
    logic         clamp;
    logic [13:0]  charge;
    ccdrt_route_t route;
    ccdrt_pix_t   sense;
    ccdrt_pix_t   low;
    ccdrt_pix_t   mult;
    ccdrt_pix_t   cand [0:8191];
    int           fails      = 0;
    int           n_compared = 0;
    int           t_glob     = 0;
    int           cycles     = 0;

    always #4 i_clock = ~i_clock;

    ccdrt_readout u_dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
        .i_horizontal_storage_clock(hclk), .i_line_start(lstart),
        .i_route(route), .i_charge(charge),
        .o_floating_gate_sense_out(sense), .o_low_gain_out(low),
        .o_multiplied_out(mult));

    ccdrt_timing_gen u_gen (.i_clock(i_clock), .i_sense(sense),
        .o_hclk(hclk), .o_line_start(lstart), .o_route(route),
        .o_charge(charge), .o_clamp(clamp));

    // every third pixel bright, the rest dim and row-marked
    function automatic logic [13:0] pat(int r, int c);
        return (c % 3 == 0) ? (14'h2000 | 14'(c))
                            : {7'h00, 2'(r), 5'(c)};
    endfunction

    task automatic check(input ccdrt_pix_t got, input ccdrt_pix_t exp);
        n_compared++;
        if (exp.valid ? (got !== exp) : (got.valid !== 1'b0))
        begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic do_reset();
        i_arst_n = 1'b0;
        repeat (2) @(negedge i_clock);
        check(sense, '0);
        check(low, '0);
        check(mult, '0);
        i_arst_n = 1'b1;
        t_glob   = 0;
        foreach (cand[i])
            cand[i] = '0;
        @(negedge i_clock);
    endtask

    task automatic run_row(int r, int len, logic bad);
        ccdrt_pix_t e;
        u_gen.start_line();
        for (int k = 1; k <= len; k++)
        begin
            u_gen.pixel((k <= 969) ? pat(r, k - 1) : 14'h3FFF, bad);
            t_glob++;
            e.valid  = (k >= 34) && (k <= 1002);
            e.charge = pat(r, k - 34);
            check(sense, e);
            e.valid  = (k >= 68) && (k <= 1036) && !bad;
            e.charge = pat(r, k - 68);
            cand[t_glob]       = e;
            cand[t_glob].valid = e.valid && (e.charge < 14'h0B4);
            e.valid  = e.valid && (e.charge >= 14'h0B4);
            check(low, e);
            e = (t_glob > 2072) ? cand[t_glob - 2072] : '0;
            check(mult, e);
        end
    endtask

    task automatic dual_mode();
        u_gen.frame_transfer();
        for (int r = 0; r < 3; r++)
            run_row(r, 1036, 1'b0);
    endtask

    task automatic single_mode();
        u_gen.frame_transfer();
        for (int r = 0; r < 2; r++)
            run_row(r, 2072, 1'b0);
        run_row(2, 1036, 1'b1);
    endtask

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fails++;
            close_out();
        end
    end

    initial
    begin
        do_reset();
        dual_mode();
        do_reset();
        single_mode();
        close_out();
    end
endmodule // tb_top
